// ---- design/dfs_sequencer.sv ----
// Command dispatch, checks and overlap control for two flash arrays
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "dfs_cfg.svh"
module dfs_sequencer (
	// Clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	// APB slave
	input  wire logic [7:0]                paddr_in,
	input  wire logic                      psel_in,
	input  wire logic                      penable_in,
	input  wire logic                      pwrite_in,
	input  wire logic [31:0]               pwdata_in,
	output logic [31:0]                    prdata_out,
	output logic                           pready_out,
	output logic                           pslverr_out,
	// Operating mode pin
	input  wire logic                      special_mode_in,
	// Array engine
	output logic                           eng_start_out,
	output dfs_pkg::dfs_eng_req_type       eng_req_out,
	input  wire logic                      eng_done_in,
	input  wire logic                      eng_err_any_in,
	input  wire logic                      eng_err_unc_in,
	// Array reads from the system
	input  wire logic                      pf_rd_in,
	input  wire logic                      df_rd_in,
	output logic                           rd_invalid_out,
	output logic                           pf_rd_stall_out,
	output logic                           df_rd_stall_out
);

	// ********************
	// Functions
	// ********************
	function automatic logic code_valid(input logic [7:0] c,
		input logic spec);
		case (c)
			`DFS_CMD_ERALL, `DFS_CMD_UNSEC,
			`DFS_CMD_FMARG: code_valid = spec;
			`DFS_CMD_BKDOOR: code_valid = !spec;
			`DFS_CMD_EVALL, `DFS_CMD_EVBLK, `DFS_CMD_EVPSEC,
			`DFS_CMD_RDONCE, `DFS_CMD_PGMP, `DFS_CMD_PGMONCE,
			`DFS_CMD_ERBLK, `DFS_CMD_ERPSEC, `DFS_CMD_UMARG,
			`DFS_CMD_EVDSEC, `DFS_CMD_PGMD,
			`DFS_CMD_ERDSEC: code_valid = 1'b1;
			default: code_valid = 1'b0;
		endcase
	endfunction

	function automatic logic prog_erase(input logic [7:0] c);
		case (c)
			`DFS_CMD_PGMP, `DFS_CMD_PGMONCE, `DFS_CMD_ERALL,
			`DFS_CMD_ERBLK, `DFS_CMD_ERPSEC, `DFS_CMD_UNSEC,
			`DFS_CMD_PGMD, `DFS_CMD_ERDSEC: prog_erase = 1'b1;
			default: prog_erase = 1'b0;
		endcase
	endfunction

	// Class of work a command puts on one array
	function automatic dfs_pkg::dfs_op_type op_class(
		input logic [7:0] c, input logic dsel, input logic is_df);
		op_class = dfs_pkg::OP_NONE;
		case (c)
			`DFS_CMD_EVALL: op_class = dfs_pkg::OP_READ;
			`DFS_CMD_EVBLK:
				if (dsel == is_df)
					op_class = dfs_pkg::OP_READ;
			`DFS_CMD_ERALL, `DFS_CMD_UNSEC:
				op_class = dfs_pkg::OP_MASS;
			`DFS_CMD_ERBLK:
				if (dsel == is_df)
					op_class = dfs_pkg::OP_MASS;
			`DFS_CMD_EVPSEC, `DFS_CMD_RDONCE:
				if (!is_df)
					op_class = dfs_pkg::OP_READ;
			`DFS_CMD_PGMP, `DFS_CMD_PGMONCE:
				if (!is_df)
					op_class = dfs_pkg::OP_PROG;
			`DFS_CMD_ERPSEC:
				if (!is_df)
					op_class = dfs_pkg::OP_SECT;
			`DFS_CMD_EVDSEC:
				if (is_df)
					op_class = dfs_pkg::OP_READ;
			`DFS_CMD_PGMD:
				if (is_df)
					op_class = dfs_pkg::OP_PROG;
			`DFS_CMD_ERDSEC:
				if (is_df)
					op_class = dfs_pkg::OP_SECT;
			default: op_class = dfs_pkg::OP_NONE;
		endcase
	endfunction

	// A read on an array whose margin level is not normal is a margin read
	function automatic dfs_pkg::dfs_op_type rd_class(
		input dfs_pkg::dfs_op_type op, input logic [15:0] lvl);
		if (op == dfs_pkg::OP_READ && lvl != 16'h0000)
			rd_class = dfs_pkg::OP_MARGIN;
		else
			rd_class = op;
	endfunction

	// Pairs that may run on the two arrays at once
	function automatic logic overlap_ok(input dfs_pkg::dfs_op_type p,
		input dfs_pkg::dfs_op_type d);
		if (p == dfs_pkg::OP_NONE || d == dfs_pkg::OP_NONE)
			overlap_ok = 1'b1;
		else if (p == dfs_pkg::OP_READ)
			overlap_ok = d == dfs_pkg::OP_MARGIN ||
				d == dfs_pkg::OP_PROG || d == dfs_pkg::OP_SECT;
		else
			overlap_ok = (p == d) && p != dfs_pkg::OP_PROG;
	endfunction

	// ********************
	// Mode pin synchroniser
	// ********************
	logic sm1_q, sm2_q, sm3_q, special_q;
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sm1_q <= 1'b0;
			sm2_q <= 1'b0;
			sm3_q <= 1'b0;
			special_q <= 1'b0;
		end else begin
			sm1_q <= special_mode_in;
			sm2_q <= sm1_q;
			sm3_q <= sm2_q;
			if (sm2_q == sm3_q)
				special_q <= sm3_q;
		end
	end

	// ********************
	// Bus decode
	// ********************
	logic                    wr, command_complete_flag, launch, acc_err, prot_err;
	logic                    dsel, immed, inv, pf_inv, df_inv;
	logic [7:0]              code;
	logic [6:0]              div_q;
	logic                    div_ld_q, access_error_flag_q, protection_violation_flag_q;
	logic                    mg1_q, mg0_q, sfd_q, dfd_q;
	logic [2:0]              idx_q;
	logic [3:0]              prot_q;
	logic [15:0]             pf_mlvl_q, df_mlvl_q;
	logic [15:0]             param_q [`DFS_NWORDS];
	logic [95:0]             words;
	dfs_pkg::dfs_state_type  state_q;
	dfs_pkg::dfs_eng_req_type cur_q;
	dfs_pkg::dfs_op_type     pf_busy, df_busy, pf_rc, df_rc;

	assign wr = psel_in && penable_in && pwrite_in;
	assign command_complete_flag = state_q == dfs_pkg::ST_IDLE;
	assign code = param_q[0][15:8];
	assign dsel = param_q[0][1:0] == `DFS_DF_BLK;
	assign immed = code == `DFS_CMD_UMARG || code == `DFS_CMD_FMARG;
	assign launch = wr && paddr_in == `DFS_OFF_STAT && command_complete_flag &&
		pwdata_in[`DFS_ST_COMMAND_COMPLETE_FLAG];

	always_comb begin
		for (int i = 0; i < `DFS_NWORDS; i++)
			words[i*16 +: 16] = param_q[i];
	end

	// ********************
	// Launch checks
	// ********************
	always_comb begin
		acc_err = !code_valid(code, special_q);
		if (prog_erase(code) && !div_ld_q)
			acc_err = 1'b1;
		if (code == `DFS_CMD_EVALL && idx_q != 3'h0)
			acc_err = 1'b1;
		if (code == `DFS_CMD_PGMD && (idx_q < `DFS_IDX_PGMD_LO ||
			idx_q > `DFS_IDX_PGMD_HI))
			acc_err = 1'b1;
	end

	// Only erase-all and erase-block check protection; verify never does
	always_comb begin
		prot_err = 1'b0;
		if (code == `DFS_CMD_ERALL)
			prot_err = !(&prot_q);
		else if (code == `DFS_CMD_ERBLK)
			prot_err = dsel ? !prot_q[`DFS_PR_DOPEN] :
				!(prot_q[`DFS_PR_PLO] && prot_q[`DFS_PR_PHI] &&
				prot_q[`DFS_PR_POPEN]);
	end

	// ********************
	// Command state
	// ********************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= dfs_pkg::ST_IDLE;
			eng_start_out <= 1'b0;
			cur_q <= '0;
		end else begin
			eng_start_out <= 1'b0;
			case (state_q)
				dfs_pkg::ST_IDLE:
					if (launch && !acc_err && !prot_err && !immed) begin
						state_q <= dfs_pkg::ST_BUSY;
						eng_start_out <= 1'b1;
						cur_q.code <= code;
						cur_q.pf_op <= rd_class(op_class(code, dsel, 1'b0),
							pf_mlvl_q);
						cur_q.df_op <= rd_class(op_class(code, dsel, 1'b1),
							df_mlvl_q);
						cur_q.words <= words;
					end
				dfs_pkg::ST_BUSY:
					if (eng_done_in)
						state_q <= dfs_pkg::ST_IDLE;
				default: state_q <= dfs_pkg::ST_IDLE;
			endcase
		end
	end
	assign eng_req_out = cur_q;

	// Error and margin status; a set beats a clear in the same cycle
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			access_error_flag_q <= 1'b0;
			protection_violation_flag_q <= 1'b0;
			mg1_q <= 1'b0;
			mg0_q <= 1'b0;
		end else begin
			if (wr && paddr_in == `DFS_OFF_STAT) begin
				if (pwdata_in[`DFS_ST_ACCESS_ERROR_FLAG])
					access_error_flag_q <= 1'b0;
				if (pwdata_in[`DFS_ST_PROTECTION_VIOLATION_FLAG])
					protection_violation_flag_q <= 1'b0;
			end
			if (launch) begin
				mg1_q <= 1'b0;
				mg0_q <= 1'b0;
				if (acc_err)
					access_error_flag_q <= 1'b1;
				else if (prot_err)
					protection_violation_flag_q <= 1'b1;
			end
			if (state_q == dfs_pkg::ST_BUSY && eng_done_in) begin
				mg1_q <= eng_err_any_in;
				mg0_q <= eng_err_unc_in;
			end
		end
	end

	// ********************
	// Register writes
	// ********************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_q <= 7'h00;
			div_ld_q <= 1'b0;
			prot_q <= 4'h0;
		end else if (wr && paddr_in == `DFS_OFF_DIV) begin
			div_q <= pwdata_in[6:0];
			div_ld_q <= 1'b1;
		end else if (wr && paddr_in == `DFS_OFF_PROT) begin
			prot_q <= pwdata_in[3:0];
		end
	end

	// Parameter words are frozen while a command runs
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			idx_q <= 3'h0;
			for (int i = 0; i < `DFS_NWORDS; i++)
				param_q[i] <= 16'h0000;
		end else if (wr && command_complete_flag) begin
			if (paddr_in == `DFS_OFF_IDX)
				idx_q <= pwdata_in[2:0];
			if (paddr_in == `DFS_OFF_PARAM &&
				idx_q < 3'(`DFS_NWORDS))
				param_q[idx_q] <= pwdata_in[15:0];
		end
	end

	// Margin levels apply at once, no array work is needed
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pf_mlvl_q <= 16'h0000;
			df_mlvl_q <= 16'h0000;
		end else if (launch && immed && !acc_err) begin
			if (dsel)
				df_mlvl_q <= param_q[1];
			else
				pf_mlvl_q <= param_q[1];
		end
	end

	// ********************
	// Array read control
	// ********************
	assign pf_busy = command_complete_flag ? dfs_pkg::OP_NONE : cur_q.pf_op;
	assign df_busy = command_complete_flag ? dfs_pkg::OP_NONE : cur_q.df_op;
	assign pf_rc = rd_class(dfs_pkg::OP_READ, pf_mlvl_q);
	assign df_rc = rd_class(dfs_pkg::OP_READ, df_mlvl_q);
	// Each array judges its own read; a bad read on one must not hide
	// a stall on the other
	assign pf_inv = pf_rd_in && pf_busy != dfs_pkg::OP_NONE;
	assign df_inv = df_rd_in && df_busy != dfs_pkg::OP_NONE;
	assign inv = pf_inv || df_inv;
	assign rd_invalid_out = inv;
	assign pf_rd_stall_out = pf_rd_in && !pf_inv &&
		!overlap_ok(pf_rc, df_busy);
	assign df_rd_stall_out = df_rd_in && !df_inv &&
		!overlap_ok(pf_busy, df_rc);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sfd_q <= 1'b0;
			dfd_q <= 1'b0;
		end else if (inv && !sfd_q && !dfd_q) begin
			sfd_q <= 1'b1;
			dfd_q <= 1'b1;
		end else if (wr && paddr_in == `DFS_OFF_FAULT) begin
			if (pwdata_in[0])
				sfd_q <= 1'b0;
			if (pwdata_in[1])
				dfd_q <= 1'b0;
		end
	end

	// ********************
	// Read data
	// ********************
	// Captured in the setup cycle so the answer comes with no wait
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in) begin
			case (paddr_in)
				`DFS_OFF_DIV:
					prdata_out <= {24'h0, div_ld_q, div_q};
				`DFS_OFF_IDX: prdata_out <= {29'h0, idx_q};
				`DFS_OFF_STAT:
					prdata_out <= {24'h0, command_complete_flag, 1'b0, access_error_flag_q,
						protection_violation_flag_q, 2'h0, mg1_q, mg0_q};
				`DFS_OFF_PROT: prdata_out <= {28'h0, prot_q};
				`DFS_OFF_PARAM:
					prdata_out <= idx_q < 3'(`DFS_NWORDS) ?
						{16'h0, param_q[idx_q]} : 32'h0;
				`DFS_OFF_FAULT:
					prdata_out <= {30'h0, dfd_q, sfd_q};
				`DFS_OFF_MARGIN:
					prdata_out <= {df_mlvl_q, pf_mlvl_q};
				default: prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	assign pready_out = 1'b1;
	always_comb begin
		case (paddr_in)
			`DFS_OFF_DIV, `DFS_OFF_IDX, `DFS_OFF_STAT,
			`DFS_OFF_PROT, `DFS_OFF_PARAM, `DFS_OFF_FAULT,
			`DFS_OFF_MARGIN: pslverr_out = 1'b0;
			default: pslverr_out = psel_in && penable_in;
		endcase
	end

	// ********************
	// Checks
	// ********************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_good_launch;
		launch && !acc_err && !prot_err && !immed;
	endsequence

	chk_launch_busy: assert property (
		s_good_launch |=> !command_complete_flag && $rose(eng_start_out))
		else $error("valid launch did not start command");
	chk_bad_code: assert property (
		launch && !code_valid(code, special_q) |=> access_error_flag_q && command_complete_flag)
		else $error("invalid code not refused");
	chk_div_uninit: assert property (
		launch && prog_erase(code) && !div_ld_q |=> access_error_flag_q && command_complete_flag)
		else $error("program before divider setup not refused");
	chk_evall_index: assert property (
		launch && code == `DFS_CMD_EVALL && idx_q != 3'h0
		|=> access_error_flag_q && !eng_start_out)
		else $error("verify-all index error missed");
	chk_mass_prot: assert property (
		launch && code == `DFS_CMD_ERALL && !(&prot_q) && !acc_err
		|=> protection_violation_flag_q && command_complete_flag)
		else $error("mass erase without protection open ran");
	chk_evall_noviol: assert property (
		launch && code == `DFS_CMD_EVALL && !protection_violation_flag_q |=> !protection_violation_flag_q)
		else $error("verify-all raised violation");
	chk_param_locked: assert property (
		!command_complete_flag ##1 !command_complete_flag |-> $stable(words) && $stable(idx_q))
		else $error("parameters changed while busy");
	chk_done_command_complete_flag: assert property (
		!command_complete_flag && eng_done_in |=> command_complete_flag ##1 command_complete_flag || launch)
		else $error("completion flag not returned");
	chk_fault_set: assert property (
		inv && !sfd_q && !dfd_q |=> sfd_q && dfd_q)
		else $error("fault flags not set on invalid read");
	chk_pf_rww: assert property (
		pf_rd_in && pf_rc == dfs_pkg::OP_READ &&
		df_busy == dfs_pkg::OP_PROG |-> !pf_rd_stall_out && !pf_inv)
		else $error("program read stalled by data program");
endmodule

// ---- design/dfs_cfg.svh ----
// Constants of the dual flash command sequencer
//
// Overview of operation
// - Code 0x01 verifies all blocks erased; 0x02 verifies one selected block.
// - Code 0x08 erases all blocks only if all four open bits are set.
// - Code 0x09 erases one block; data block needs its open bit set.
// - Code 0x0B erases all blocks then verifies them to release security.
// - Code 0x0D sets the user margin read level of the selected block.
// - Code 0x0E sets the field margin level, accepted only in special mode.
// - Code 0x10 verifies a counted run of data flash words is erased.
// - Code 0x11 programs one to four data flash words in one command.
// - Code 0x12 erases every byte of one data flash sector.
// - Program reads run while data flash margin reads, programs or sector erases.
// - Other overlaps are limited to the pairs of the overlap table.
// - A read after a non-normal margin level counts as a margin read.
// - Erase-all and erase-block both count as mass erase for overlaps.
// - Program or erase before divider setup raises access error, not run.
// - An invalid command code raises access error and is not run.
// - A read of a block busy with a command returns invalid data.
// - Such a read sets both fault flags when neither was already set.
// - Erase-verify-all checks the whole space, completion flag sets at end.
// - Erase-verify-all raises access error when the index is not 000.
// - Verify reads set margin status bits; never the violation flag.
// - Writing 1 to the completion flag launches; it stays low until done.
// - Parameter writes are ignored while the completion flag is low.
// - The parameter index selects the parameter word that is accessed.
`ifndef DFS_CFG_SVH
`define DFS_CFG_SVH
// Register byte offsets
`define DFS_OFF_DIV     8'h00
`define DFS_OFF_IDX     8'h04
`define DFS_OFF_STAT    8'h08
`define DFS_OFF_PROT    8'h0c
`define DFS_OFF_PARAM   8'h10
`define DFS_OFF_FAULT   8'h14
`define DFS_OFF_MARGIN  8'h18
// Status bit positions
`define DFS_ST_COMMAND_COMPLETE_FLAG     7
`define DFS_ST_ACCESS_ERROR_FLAG   5
`define DFS_ST_PROTECTION_VIOLATION_FLAG   4
`define DFS_ST_MG1      1
`define DFS_ST_MG0      0
// Protection bit positions
`define DFS_PR_PLO      0
`define DFS_PR_PHI      1
`define DFS_PR_POPEN    2
`define DFS_PR_DOPEN    3
// Divider fields
`define DFS_DIV_LOADED  7
// Parameter words and block select
`define DFS_NWORDS      6
`define DFS_DF_BLK      2'h0
`define DFS_IDX_PGMD_LO 3'h2
`define DFS_IDX_PGMD_HI 3'h5
// Command codes
`define DFS_CMD_EVALL   8'h01
`define DFS_CMD_EVBLK   8'h02
`define DFS_CMD_EVPSEC  8'h03
`define DFS_CMD_RDONCE  8'h04
`define DFS_CMD_PGMP    8'h06
`define DFS_CMD_PGMONCE 8'h07
`define DFS_CMD_ERALL   8'h08
`define DFS_CMD_ERBLK   8'h09
`define DFS_CMD_ERPSEC  8'h0a
`define DFS_CMD_UNSEC   8'h0b
`define DFS_CMD_BKDOOR  8'h0c
`define DFS_CMD_UMARG   8'h0d
`define DFS_CMD_FMARG   8'h0e
`define DFS_CMD_EVDSEC  8'h10
`define DFS_CMD_PGMD    8'h11
`define DFS_CMD_ERDSEC  8'h12
`endif

// ---- design/dfs_pkg.sv ----
// Types of the dual flash command sequencer
package dfs_pkg;
	typedef enum logic [2:0] {
		OP_NONE, OP_READ, OP_MARGIN, OP_PROG, OP_SECT, OP_MASS
	} dfs_op_type;
	typedef enum logic {ST_IDLE, ST_BUSY} dfs_state_type;
	// Command handed to the array engine
	typedef struct packed {
		logic [7:0]  code;
		dfs_op_type  pf_op;
		dfs_op_type  df_op;
		logic [95:0] words;
	} dfs_eng_req_type;
endpackage

// ---- test/tb.sv ----
// Self-checking bench for the dual flash command sequencer
`timescale 1ns/1ns
`include "dfs_cfg.svh"
module tb;
	// ************************************************************
	// Signals
	// ************************************************************
	logic                     ref_clk_in, rst_in, smode;
	logic                     psel, penable, pwrite, pready, pslverr, se;
	logic [7:0]               paddr;
	logic [31:0]              pwdata, prdata, rv;
	logic                     eng_start, eng_done, err_any, err_unc;
	dfs_pkg::dfs_eng_req_type eng_req;
	logic                     pf_rd, df_rd, rd_inv, pf_stall, df_stall;
	logic [2:0]               pv;
	int                       error_cnt, tests_run, starts, s0, cyc;
	// Command table: code, expected ops, expected {invalid, stalls}
	logic [7:0] cd [7] = '{8'h10, 8'h11, 8'h12, 8'h06, 8'h08, 8'h09, 8'h0b};
	logic [2:0] rp [7] = '{3'h6, 3'h4, 3'h4, 3'h5, 3'h4, 3'h6, 3'h4};
	dfs_pkg::dfs_op_type po [7] = '{dfs_pkg::OP_NONE, dfs_pkg::OP_NONE,
		dfs_pkg::OP_NONE, dfs_pkg::OP_PROG, dfs_pkg::OP_MASS,
		dfs_pkg::OP_NONE, dfs_pkg::OP_MASS};
	dfs_pkg::dfs_op_type dp [7] = '{dfs_pkg::OP_READ, dfs_pkg::OP_PROG,
		dfs_pkg::OP_SECT, dfs_pkg::OP_NONE, dfs_pkg::OP_MASS,
		dfs_pkg::OP_MASS, dfs_pkg::OP_MASS};

	dfs_sequencer dfs_sequencer_inst (
		.ref_clk_in      (ref_clk_in),
		.rst_in          (rst_in),
		.paddr_in        (paddr),
		.psel_in         (psel),
		.penable_in      (penable),
		.pwrite_in       (pwrite),
		.pwdata_in       (pwdata),
		.prdata_out      (prdata),
		.pready_out      (pready),
		.pslverr_out     (pslverr),
		.special_mode_in (smode),
		.eng_start_out   (eng_start),
		.eng_req_out     (eng_req),
		.eng_done_in     (eng_done),
		.eng_err_any_in  (err_any),
		.eng_err_unc_in  (err_unc),
		.pf_rd_in        (pf_rd),
		.df_rd_in        (df_rd),
		.rd_invalid_out  (rd_inv),
		.pf_rd_stall_out (pf_stall),
		.df_rd_stall_out (df_stall)
	);

	// ************************************************************
	// Clock, watchdog and engine start count
	// ************************************************************
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	// Whole run needs about 500 cycles, so 6000 means a hang
	always @(posedge ref_clk_in) begin
		cyc = cyc + 1;
		if (eng_start === 1'b1) begin
			starts = starts + 1;
		end
		if (cyc == 6000) begin
			error_cnt = error_cnt + 1;
			conclude();
		end
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run = tests_run + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	// Request held until pready is seen high with psel and penable
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		@(posedge ref_clk_in);
		while (pready !== 1'b1) @(posedge ref_clk_in);
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rv);
	endtask
	task cmd(input logic [15:0] w0, input logic [15:0] w1,
		input logic [2:0] ix);
		apb(1'b1, `DFS_OFF_IDX, 32'h0);
		apb(1'b1, `DFS_OFF_PARAM, {16'h0, w0});
		apb(1'b1, `DFS_OFF_IDX, 32'h1);
		apb(1'b1, `DFS_OFF_PARAM, {16'h0, w1});
		apb(1'b1, `DFS_OFF_IDX, {29'h0, ix});
		apb(1'b1, `DFS_OFF_STAT, 32'h80);
	endtask
	// Read strobes for one cycle; pins sampled mid-cycle
	task probe(input logic p, input logic d);
		@(posedge ref_clk_in);
		pf_rd <= p;
		df_rd <= d;
		@(negedge ref_clk_in);
		pv = {rd_inv, pf_stall, df_stall};
		@(posedge ref_clk_in);
		pf_rd <= 1'b0;
		df_rd <= 1'b0;
	endtask
	task done(input logic a, input logic u);
		@(posedge ref_clk_in);
		eng_done <= 1'b1;
		err_any <= a;
		err_unc <= u;
		@(posedge ref_clk_in);
		eng_done <= 1'b0;
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{rst_in, psel, penable, pwrite, paddr, pwdata} = '1;
		{psel, penable, pwrite, paddr, pwdata, smode} = '0;
		{eng_done, err_any, err_unc, pf_rd, df_rd} = '0;
		{error_cnt, tests_run, starts, cyc} = '0;
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rdc("status", `DFS_OFF_STAT, 32'h80);
		rdc("divider", `DFS_OFF_DIV, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, se});
		$display("test reset done");
		// Refusals in normal mode, divider still unwritten
		apb(1'b1, `DFS_OFF_PROT, 32'hf);
		cmd(16'h0900, 16'h0, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'ha0);
		apb(1'b1, `DFS_OFF_STAT, 32'h20);
		cmd(16'h0500, 16'h0, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'ha0);
		apb(1'b1, `DFS_OFF_STAT, 32'h20);
		cmd(16'h0e00, 16'h0, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'ha0);
		apb(1'b1, `DFS_OFF_STAT, 32'h20);
		chk("starts", 32'h0, starts);
		$display("test refusals done");
		// Index checks and verify-all with busy reads
		apb(1'b1, `DFS_OFF_DIV, 32'h05);
		rdc("divider", `DFS_OFF_DIV, 32'h85);
		cmd(16'h0100, 16'habcd, 3'h1);
		rdc("status", `DFS_OFF_STAT, 32'ha0);
		apb(1'b1, `DFS_OFF_STAT, 32'h20);
		apb(1'b1, `DFS_OFF_IDX, 32'h2);
		apb(1'b1, `DFS_OFF_PARAM, 32'h1111);
		apb(1'b1, `DFS_OFF_IDX, 32'h1);
		rdc("param", `DFS_OFF_PARAM, 32'habcd);
		cmd(16'h0100, 16'h0, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'h0);
		chk("code", 32'h01, {24'h0, eng_req.code});
		chk("words", 32'h0000_0100, eng_req.words[31:0]);
		chk("ops", {26'h0, dfs_pkg::OP_READ, dfs_pkg::OP_READ},
			{26'h0, eng_req.pf_op, eng_req.df_op});
		apb(1'b1, `DFS_OFF_PARAM, 32'h5555);
		probe(1'b1, 1'b0);
		chk("read pins", 32'h4, {29'h0, pv});
		rdc("faults", `DFS_OFF_FAULT, 32'h3);
		apb(1'b1, `DFS_OFF_FAULT, 32'h1);
		probe(1'b0, 1'b1);
		rdc("faults", `DFS_OFF_FAULT, 32'h2);
		done(1'b1, 1'b1);
		rdc("status", `DFS_OFF_STAT, 32'h83);
		rdc("param", `DFS_OFF_PARAM, 32'h0100);
		$display("test verify all done");
		// Protection refusals and the command table in special mode
		smode <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		apb(1'b1, `DFS_OFF_PROT, 32'h7);
		cmd(16'h0800, 16'h0, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'h90);
		apb(1'b1, `DFS_OFF_STAT, 32'h10);
		cmd(16'h0900, 16'h0, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'h90);
		apb(1'b1, `DFS_OFF_STAT, 32'h10);
		apb(1'b1, `DFS_OFF_PROT, 32'hf);
		for (int i = 0; i < 7; i++) begin
			cmd({cd[i], 8'h00}, 16'h0, (cd[i] == 8'h11) ? 3'h5 : 3'h0);
			probe(1'b1, 1'b1);
			chk("read pins", {29'h0, rp[i]}, {29'h0, pv});
			chk("code", {24'h0, cd[i]}, {24'h0, eng_req.code});
			chk("ops", {26'h0, po[i], dp[i]},
				{26'h0, eng_req.pf_op, eng_req.df_op});
			done(1'b0, 1'b0);
			rdc("status", `DFS_OFF_STAT, 32'h80);
		end
		$display("test command table done");
		// Margin levels change the read class
		s0 = starts;
		cmd(16'h0d00, 16'h0001, 3'h0);
		rdc("status", `DFS_OFF_STAT, 32'h80);
		rdc("margin", `DFS_OFF_MARGIN, 32'h00010000);
		chk("starts", s0, starts);
		cmd(16'h1000, 16'h0, 3'h0);
		probe(1'b1, 1'b0);
		chk("read pins", 32'h0, {29'h0, pv});
		done(1'b0, 1'b0);
		cmd(16'h0e00, 16'h0, 3'h0);
		rdc("margin", `DFS_OFF_MARGIN, 32'h0);
		$display("test margin done");
		conclude();
	end
endmodule
